// ==== design/cvt_top.v ====
// Operation
// - Enabled port reads return successive vector words
// - Enabled port writes load successive vector words
// - Fixed address streaming of port accesses allowed
// - Gain trim for input A, 8 bits
// - Gain trim for input B, 8 bits
// - Reference trim is 4 bits, upper reserved
// - Termination trim for input A, 8 bits
// - Trims load fuse values after reset
// - Port enabled only by enable bit 0
//
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ns
`include "cvt_defines.vh"

module cvt_top (
    // Clock and reset
    input  wire        clk_sys_i,
    input  wire        rst_n_i,
    // AXI4-Lite write address
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [11:0] s_axi_awaddr,
    // AXI4-Lite write data
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    // AXI4-Lite write response
    output wire        s_axi_bvalid,
    input  wire        s_axi_bready,
    output wire [1:0]  s_axi_bresp,
    // AXI4-Lite read address
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    input  wire [11:0] s_axi_araddr,
    // AXI4-Lite read data
    output wire        s_axi_rvalid,
    input  wire        s_axi_rready,
    output wire [31:0] s_axi_rdata,
    output wire [1:0]  s_axi_rresp,
    // Calibration engine side
    input  wire        calibration_halted_flag_i,
    input  wire [7:0]  cal_rdata_i,
    output wire        cal_rd_o,
    output wire        cal_wr_o,
    output wire [7:0]  cal_wdata_o,
    output wire [9:0]  cal_index_o,
    // Fuse storage values
    input  wire [7:0]  fuse_gain_a_i,
    input  wire [7:0]  fuse_gain_b_i,
    input  wire [3:0]  fuse_ref_i,
    input  wire [7:0]  fuse_term_a_i,
    // Trim outputs to the analogue side
    output wire [7:0]  input_a_gain_trim_o,
    output wire [7:0]  input_b_gain_trim_o,
    output wire [3:0]  reference_voltage_trim_o,
    output wire [7:0]  input_a_termination_trim_o
);

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------
    // One-hot select: en, port, status, gain a, gain b, ref, term a
    function [6:0] cvt_decode;
        input [11:0] addr;
        begin
            cvt_decode = 7'h00;
            if (addr[1:0] == 2'h0) begin
                case (addr[11:2])
                    {2'h0, `CVT_IDX_VEC_ENABLE}: cvt_decode = 7'h01;
                    {2'h0, `CVT_IDX_VEC_PORT}:   cvt_decode = 7'h02;
                    {2'h0, `CVT_IDX_STATUS}:     cvt_decode = 7'h04;
                    {2'h0, `CVT_IDX_GAIN_A}:     cvt_decode = 7'h08;
                    {2'h0, `CVT_IDX_GAIN_B}:     cvt_decode = 7'h10;
                    {2'h0, `CVT_IDX_REF_TRIM}:   cvt_decode = 7'h20;
                    {2'h0, `CVT_IDX_TERM_A}:     cvt_decode = 7'h40;
                    default:                     cvt_decode = 7'h00;
                endcase
            end
        end
    endfunction

    // Next word index with wrap after the last vector word
    function [9:0] cvt_next_index;
        input [9:0] idx;
        begin
            if (idx == `CVT_VEC_LAST) begin
                cvt_next_index = 10'h000;
            end else begin
                cvt_next_index = idx + 10'h001;
            end
        end
    endfunction

    // ------------------------------------------------------------------------
    // Read path states
    // ------------------------------------------------------------------------
    localparam [2:0] RD_IDLE = 3'b001;  // Ready for an address
    localparam [2:0] RD_STRB = 3'b010;  // Engine strobe cycle
    localparam [2:0] RD_PUSH = 3'b100;  // Offering the answer to the buffer

    // ------------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------------
    reg  [7:0]  vec_enable;      // Enable register, all bits stored
    reg  [7:0]  gain_a;          // Gain trim input A
    reg  [7:0]  gain_b;          // Gain trim input B
    reg  [3:0]  ref_trim;        // Reference trim field
    reg  [7:0]  term_a;          // Termination trim input A
    reg         fuse_loaded;     // Fuse copy done
    reg  [9:0]  word_index;      // Position in the vector
    reg         run_access_err;  // Port touched while calibration ran
    reg         aw_held;         // Write address captured
    reg  [11:0] aw_addr;         // Captured write address
    reg         w_held;          // Write data captured
    reg  [31:0] w_data;          // Captured write data
    reg  [3:0]  w_strb;          // Captured byte enables
    reg         bvalid;          // Write answer pending
    reg  [1:0]  bresp;           // Write answer code
    reg  [2:0]  rd_state;        // Read path state
    reg  [6:0]  rd_sel;          // Decoded read select
    reg         rd_strobe;       // Engine read strobe
    reg  [33:0] rd_word;         // Answer offered to the buffer
    reg         wr_strobe;       // Engine write strobe
    reg  [7:0]  wr_byte;         // Byte sent to the engine
    reg  [31:0] next_rdata;      // Read mux result
    wire [6:0]  wr_sel;          // Decoded write select
    wire        wr_go;           // Write executes this cycle
    wire        wr_lane0;        // Low byte lane enabled
    wire        port_on;         // Vector access enabled
    wire        en_rise;         // Enable newly set by this write
    wire        wr_port;         // Write reaches the engine
    wire        rd_port;         // Read reaches the engine
    wire        buf_in_ready;    // Buffer can take the answer
    wire [33:0] buf_out;         // Buffer head

    assign wr_sel   = cvt_decode(aw_addr);
    assign wr_lane0 = w_strb[0];
    // Reads hold the strobe cycle, so a write waits to keep the index order
    assign wr_go    = aw_held & w_held & ~bvalid & (rd_state != RD_STRB);
    assign port_on  = vec_enable[`CVT_EN_BIT];
    assign en_rise  = wr_go & wr_sel[0] & wr_lane0 & w_data[`CVT_EN_BIT] & ~port_on;
    assign wr_port  = wr_go & wr_sel[1] & wr_lane0 & port_on;
    assign rd_port  = (rd_state == RD_STRB) & rd_sel[1] & port_on;

    // ------------------------------------------------------------------------
    // Write channel capture
    // ------------------------------------------------------------------------
    // Address and data are taken independently, in either order
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            aw_held <= 1'b0;
            aw_addr <= 12'h000;
            w_held  <= 1'b0;
            w_data  <= 32'h00000000;
            w_strb  <= 4'h0;
        end else begin
            // Address side
            if (s_axi_awvalid & ~aw_held) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_held <= 1'b0;
            end
            // Data side
            if (s_axi_wvalid & ~w_held) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held <= 1'b0;
            end
        end
    end

    assign s_axi_awready = ~aw_held;
    assign s_axi_wready  = ~w_held;

    // ------------------------------------------------------------------------
    // Write response
    // ------------------------------------------------------------------------
    // Unmapped addresses answer decode error and change nothing
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            bvalid <= 1'b0;
            bresp  <= `CVT_RESP_OKAY;
        end else if (wr_go) begin
            bvalid <= 1'b1;
            bresp  <= (|wr_sel) ? `CVT_RESP_OKAY : `CVT_RESP_DECERR;
        end else if (s_axi_bready) begin
            bvalid <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid;
    assign s_axi_bresp  = bresp;

    // ------------------------------------------------------------------------
    // Control and trim registers
    // ------------------------------------------------------------------------
    // Trims reset to zero, then copy fuse values on the first edge after
    // release; fuse pins are static, so no synchroniser is needed
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            vec_enable  <= `CVT_RST_EN;
            gain_a      <= `CVT_RST_TRIM;
            gain_b      <= `CVT_RST_TRIM;
            ref_trim    <= 4'h0;
            term_a      <= `CVT_RST_TRIM;
            fuse_loaded <= 1'b0;
        end else if (!fuse_loaded) begin
            gain_a      <= fuse_gain_a_i;
            gain_b      <= fuse_gain_b_i;
            ref_trim    <= fuse_ref_i;
            term_a      <= fuse_term_a_i;
            fuse_loaded <= 1'b1;
        end else if (wr_go & wr_lane0) begin
            // Low byte carries every field
            if (wr_sel[0]) begin
                vec_enable <= w_data[7:0];
            end
            if (wr_sel[3]) begin
                gain_a <= w_data[7:0];
            end
            if (wr_sel[4]) begin
                gain_b <= w_data[7:0];
            end
            if (wr_sel[5]) begin
                ref_trim <= w_data[`CVT_REF_TRIM_W-1:0];
            end
            if (wr_sel[6]) begin
                term_a <= w_data[7:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Vector word index
    // ------------------------------------------------------------------------
    // One shared index gives reads and writes the same word order
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            word_index <= 10'h000;
        end else if (en_rise) begin
            word_index <= 10'h000;
        end else if (wr_port | rd_port) begin
            word_index <= cvt_next_index(word_index);
        end
    end

    // ------------------------------------------------------------------------
    // Access while running flag
    // ------------------------------------------------------------------------
    // Sticky; a new enable clears it, but a same-cycle access wins
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            run_access_err <= 1'b0;
        end else if ((wr_port | rd_port) & ~calibration_halted_flag_i) begin
            run_access_err <= 1'b1;
        end else if (en_rise) begin
            run_access_err <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // Engine write strobe
    // ------------------------------------------------------------------------
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_strobe <= 1'b0;
            wr_byte   <= 8'h00;
        end else begin
            wr_strobe <= wr_port;
            if (wr_port) begin
                wr_byte <= w_data[7:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // Read path state machine
    // ------------------------------------------------------------------------
    // Back-to-back reads at one address stream words without a gap state
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rd_state  <= RD_IDLE;
            rd_sel    <= 7'h00;
            rd_strobe <= 1'b0;
            rd_word   <= 34'h0;
        end else begin
            case (rd_state)
                RD_IDLE: begin
                    // Address taken; strobe the engine in the next cycle
                    if (s_axi_arvalid) begin
                        rd_sel    <= cvt_decode(s_axi_araddr);
                        rd_state  <= RD_STRB;
                        rd_strobe <= 1'b1;
                    end
                end
                RD_STRB: begin
                    // Engine data and register values captured here
                    rd_strobe <= 1'b0;
                    rd_word   <= {((|rd_sel) ? `CVT_RESP_OKAY : `CVT_RESP_DECERR),
                                  next_rdata};
                    rd_state  <= RD_PUSH;
                end
                RD_PUSH: begin
                    // Wait for room in the buffer
                    if (buf_in_ready) begin
                        rd_state <= RD_IDLE;
                    end
                end
                default: begin
                    rd_state  <= RD_IDLE;
                    rd_strobe <= 1'b0;
                end
            endcase
        end
    end

    assign s_axi_arready = (rd_state == RD_IDLE);

    // ------------------------------------------------------------------------
    // Read data mux
    // ------------------------------------------------------------------------
    // Reserved bits read as zero; a disabled port reads zero
    always @* begin
        next_rdata = 32'h00000000;
        case (1'b1)
            rd_sel[0]: next_rdata = {24'h000000, vec_enable};
            rd_sel[1]: next_rdata = port_on ? {24'h000000, cal_rdata_i} : 32'h00000000;
            rd_sel[2]: begin
                next_rdata[`CVT_ST_HALTED_BIT] = calibration_halted_flag_i;
                next_rdata[`CVT_ST_BUSY_BIT]   = (word_index != 10'h000);
                next_rdata[`CVT_ST_ERR_BIT]    = run_access_err;
                next_rdata[`CVT_ST_IDX_LSB +: `CVT_IDX_W] = word_index;
            end
            rd_sel[3]: next_rdata = {24'h000000, gain_a};
            rd_sel[4]: next_rdata = {24'h000000, gain_b};
            rd_sel[5]: next_rdata = {28'h0000000, ref_trim};
            rd_sel[6]: next_rdata = {24'h000000, term_a};
            default:   next_rdata = 32'h00000000;
        endcase
    end

    // ------------------------------------------------------------------------
    // Read answer buffer
    // ------------------------------------------------------------------------
    // A stalled rready fills the buffer, which then holds the read path
    cvt_buf u_rbuf (
        .clk_sys_i   (clk_sys_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (rd_state == RD_PUSH),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (rd_word),
        .out_valid_o (s_axi_rvalid),
        .out_ready_i (s_axi_rready),
        .out_data_o  (buf_out)
    );

    assign s_axi_rdata = buf_out[31:0];
    assign s_axi_rresp = buf_out[33:32];

    // ------------------------------------------------------------------------
    // Outputs to engine and analogue side
    // ------------------------------------------------------------------------
    assign cal_rd_o                   = rd_strobe & rd_sel[1] & port_on;
    assign cal_wr_o                   = wr_strobe;
    assign cal_wdata_o                = wr_byte;
    assign cal_index_o                = word_index;
    assign input_a_gain_trim_o        = gain_a;
    assign input_b_gain_trim_o        = gain_b;
    assign reference_voltage_trim_o   = ref_trim;
    assign input_a_termination_trim_o = term_a;

endmodule // cvt_top

// ==== design/cvt_defines.vh ====
`ifndef CVT_DEFINES_VH
`define CVT_DEFINES_VH

// ----------------------------------------------------------------------------
// Register indexes (byte address = index * 4)
// ----------------------------------------------------------------------------
`define CVT_IDX_VEC_ENABLE   8'h70
`define CVT_IDX_VEC_PORT     8'h71
`define CVT_IDX_STATUS       8'h72
`define CVT_IDX_GAIN_A       8'h7A
`define CVT_IDX_GAIN_B       8'h7B
`define CVT_IDX_REF_TRIM     8'h7C
`define CVT_IDX_TERM_A       8'h7E

// ----------------------------------------------------------------------------
// Field positions and widths
// ----------------------------------------------------------------------------
`define CVT_EN_BIT           0
`define CVT_REF_TRIM_W       4
`define CVT_ST_HALTED_BIT    0
`define CVT_ST_BUSY_BIT      1
`define CVT_ST_ERR_BIT       2
`define CVT_ST_IDX_LSB       16
`define CVT_IDX_W            10

// ----------------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------------
`define CVT_RST_EN           8'h00
`define CVT_RST_TRIM         8'h00
`define CVT_VEC_WORDS        10'h2A1
`define CVT_VEC_LAST         10'h2A0

// ----------------------------------------------------------------------------
// Bus answers
// ----------------------------------------------------------------------------
`define CVT_RESP_OKAY        2'h0
`define CVT_RESP_DECERR      2'h3

`endif

// ==== design/cvt_buf.v ====
`timescale 1ns/1ns

// Two-entry buffer on the read answer path; data out comes from flip-flops
module cvt_buf (
    // Clock and reset
    input  wire        clk_sys_i,
    input  wire        rst_n_i,
    // Filling side
    input  wire        in_valid_i,
    output wire        in_ready_o,
    input  wire [33:0] in_data_i,
    // Draining side
    output wire        out_valid_o,
    input  wire        out_ready_i,
    output wire [33:0] out_data_o
);

    reg  [33:0] slot0;   // Head entry
    reg  [33:0] slot1;   // Second entry
    reg  [1:0]  fill;    // Entries held
    wire        push;    // Word taken in
    wire        pop;     // Word handed out

    assign in_ready_o  = (fill != 2'h2);
    assign out_valid_o = (fill != 2'h0);
    assign out_data_o  = slot0;
    assign push        = in_valid_i & in_ready_o;
    assign pop         = out_valid_o & out_ready_i;

    // ------------------------------------------------------------------------
    // Storage and fill count
    // ------------------------------------------------------------------------
    // Full blocks pushes, so a stalled drain loses nothing
    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            slot0 <= 34'h0;
            slot1 <= 34'h0;
            fill  <= 2'h0;
        end else begin
            case ({push, pop})
                2'b10: begin
                    // Fill the first free slot
                    if (fill == 2'h0) begin
                        slot0 <= in_data_i;
                    end else begin
                        slot1 <= in_data_i;
                    end
                    fill <= fill + 2'h1;
                end
                2'b01: begin
                    // Shift the second entry forward
                    slot0 <= slot1;
                    fill  <= fill - 2'h1;
                end
                2'b11: begin
                    // Pass-through when one entry; shift-and-fill when two
                    if (fill == 2'h1) begin
                        slot0 <= in_data_i;
                    end else begin
                        slot0 <= slot1;
                        slot1 <= in_data_i;
                    end
                end
                default: begin
                    fill <= fill;
                end
            endcase
        end
    end

endmodule // cvt_buf

// ==== verif/cvt_props.sv ====
`timescale 1ns/1ns
`include "cvt_defines.vh"

// Bus timing and vector strobe checks, ports of cvt_top only
module cvt_props (
    // Clock and reset
    input wire        clk_sys_i,
    input wire        rst_n_i,
    // Bus handshakes
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_bready,
    input wire [1:0]  s_axi_bresp,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire        s_axi_rready,
    input wire [31:0] s_axi_rdata,
    // Engine side
    input wire        cal_rd_o,
    input wire        cal_wr_o,
    input wire [9:0]  cal_index_o
);
    // ------------------------------------------
    // Properties
    // ------------------------------------------
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    // Both write channels taken at one edge
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_rd_strobe_pulse: assert property (cal_rd_o |=> !cal_rd_o)
        else $error("read strobe held too long");
    a_wr_strobe_pulse: assert property (cal_wr_o |=> !cal_wr_o)
        else $error("write strobe held too long");
    a_rd_answer_soon: assert property (s_rd_taken |-> ##[1:3] s_axi_rvalid)
        else $error("read answer late");
    a_rd_refuse_next: assert property (s_rd_taken |=> !s_axi_arready)
        else $error("second read taken too early");
    a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before taken");
    a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write answer dropped before taken");
    a_wr_answer_soon: assert property (s_wr_taken |-> ##[2:4] s_axi_bvalid)
        else $error("write answer late");
    // Index wraps after the last vector word
    a_rd_index_step: assert property (cal_rd_o |=> cal_index_o ==
        (($past(cal_index_o) == `CVT_VEC_LAST) ? 10'h0 : $past(cal_index_o) + 10'h1))
        else $error("index not advanced after read");
    a_wr_index_step: assert property (cal_wr_o |-> cal_index_o ==
        (($past(cal_index_o) == `CVT_VEC_LAST) ? 10'h0 : $past(cal_index_o) + 10'h1))
        else $error("index not advanced at write");
endmodule // cvt_props

// ==== verif/calibration_vector_and_trim_regs_tb.sv ====
`timescale 1ns/1ns
`include "cvt_defines.vh"

module calibration_vector_and_trim_regs_tb;
    // ------------------------------------------
    // Stimulus and observed signals
    // ------------------------------------------
    reg         clk = 1'b0, rst_n = 1'b0, halted = 1'b1; // Halted until the final check
    reg         awv = 0, wv = 0, brdy = 0, arv = 0, rrdy = 0, stl = 0;
    reg  [11:0] awa = 0, ara = 0;
    reg  [31:0] wd = 0, rv, lfsr_st = 32'hC1647A9A;
    reg  [3:0]  ws = 0, fr;
    reg  [7:0]  crd = 0, fa, fb, ft, key, wexp [0:672], tv [0:2], tix [0:2];
    reg  [1:0]  rr;
    wire        awr, wr_y, bv, arr, rvl, crd_o, cwr_o;
    wire [1:0]  bresp, rresp;
    wire [31:0] rdata;
    wire [7:0]  cwd, ta, tb, tt;
    wire [3:0]  tr;
    wire [9:0]  cidx;
    integer     n_fail = 0, checks = 0, n_rd = 0, n_wr = 0, i;

    cvt_top DUT (.clk_sys_i(clk), .rst_n_i(rst_n),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
        .s_axi_wvalid(wv), .s_axi_wready(wr_y), .s_axi_wdata(wd), .s_axi_wstrb(ws),
        .s_axi_bvalid(bv), .s_axi_bready(brdy), .s_axi_bresp(bresp),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
        .s_axi_rvalid(rvl), .s_axi_rready(rrdy), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .calibration_halted_flag_i(halted), .cal_rdata_i(crd), .cal_rd_o(crd_o),
        .cal_wr_o(cwr_o), .cal_wdata_o(cwd), .cal_index_o(cidx),
        .fuse_gain_a_i(fa), .fuse_gain_b_i(fb), .fuse_ref_i(fr), .fuse_term_a_i(ft),
        .input_a_gain_trim_o(ta), .input_b_gain_trim_o(tb),
        .reference_voltage_trim_o(tr), .input_a_termination_trim_o(tt));

    initial forever #25 clk = ~clk;
    // Watchdog, several times the expected run
    initial begin #2000000; n_fail = n_fail + 1; wrap_up; end

    function [31:0] rnd();
        lfsr_st = {lfsr_st[30:0], lfsr_st[31] ^ lfsr_st[21] ^ lfsr_st[1] ^ lfsr_st[0]};
        return lfsr_st;
    endfunction
    // Stored word per index; bits 9:8 folded in so words 256 apart differ
    function [7:0] vw(input [9:0] x);
        vw = x[7:0] ^ {6'h0, x[9:8]} ^ key;
    endfunction

    // Engine model: word for the current index, strobes counted, write data checked
    always @(posedge clk) begin
        crd <= vw(cidx);
        if (crd_o) n_rd = n_rd + 1;
        if (cwr_o) begin
            n_wr = n_wr + 1;
            chk(cwd, wexp[(cidx == 10'h0) ? 10'd672 : cidx - 10'h1]);
        end
    end

    task chk(input [31:0] got, input [31:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Write cycle; address and data offered together
    task wr(input [7:0] ix, input [31:0] d, output [1:0] r);
        reg a, w;
        @(posedge clk);
        awv <= 1'b1; awa <= {2'h0, ix, 2'h0}; wv <= 1'b1; wd <= d; ws <= 4'hF; brdy <= !stl;
        a = 1'b0; w = 1'b0;
        while (!(a && w)) begin
            @(posedge clk);
            if (!a && awr) begin a = 1'b1; awv <= 1'b0; end
            if (!w && wr_y) begin w = 1'b1; wv <= 1'b0; end
        end
        do @(posedge clk); while (!bv);
        if (stl) begin
            repeat (2) @(posedge clk);
            brdy <= 1'b1;
            @(posedge clk);
        end
        r = bresp; brdy <= 1'b0;
    endtask
    task rd(input [7:0] ix, output [31:0] d, output [1:0] r);
        @(posedge clk);
        arv <= 1'b1; ara <= {2'h0, ix, 2'h0}; rrdy <= !stl;
        do @(posedge clk); while (!arr);
        arv <= 1'b0;
        do @(posedge clk); while (!rvl);
        if (stl) begin
            repeat (2) @(posedge clk);
            rrdy <= 1'b1;
            @(posedge clk);
        end
        d = rdata; r = rresp; rrdy <= 1'b0;
    endtask
    task wc(input [7:0] ix, input [31:0] d);
        wr(ix, d, rr); chk(rr, `CVT_RESP_OKAY);
    endtask
    task rc(input [7:0] ix, input [31:0] e);
        rd(ix, rv, rr); chk(rv, e); chk(rr, `CVT_RESP_OKAY);
    endtask
    task wrap_up;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // ------------------------------------------
    // Main sequence
    // ------------------------------------------
    initial begin
        rv = rnd(); {fa, fb, ft, fr} = rv[27:0];
        rv = rnd(); key = rv[7:0];
        tix[0] = `CVT_IDX_GAIN_A; tix[1] = `CVT_IDX_GAIN_B; tix[2] = `CVT_IDX_TERM_A;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        rc(`CVT_IDX_GAIN_A, fa);
        rc(`CVT_IDX_GAIN_B, fb);
        rc(`CVT_IDX_REF_TRIM, fr);
        rc(`CVT_IDX_TERM_A, ft);
        wc(`CVT_IDX_REF_TRIM, 32'hFFFFFFFF); rc(`CVT_IDX_REF_TRIM, 32'h0F);
        chk(tr, 4'hF);
        stl = 1'b1; // Late ready: answers must wait in place
        for (i = 0; i < 3; i = i + 1) begin
            rv = rnd(); tv[i] = rv[7:0];
            wc(tix[i], rv); rc(tix[i], tv[i]);
        end
        stl = 1'b0;
        chk({ta, tb, tt}, {tv[0], tv[1], tv[2]});
        // Unmapped place answers with a decode error
        wr(8'h75, 32'h1, rr); chk(rr, `CVT_RESP_DECERR);
        rd(8'h75, rv, rr); chk(rr, `CVT_RESP_DECERR); chk(rv, 32'h0);
        rc(`CVT_IDX_VEC_PORT, 32'h0); wc(`CVT_IDX_VEC_PORT, 32'h5A);
        chk(n_rd + n_wr, 0);
        wc(`CVT_IDX_VEC_ENABLE, 32'h1);
        // Full vector plus two wrapped words, address held fixed
        for (i = 0; i < 675; i = i + 1) rc(`CVT_IDX_VEC_PORT, vw(10'(i % 673)));
        chk(n_rd, 675);
        rc(`CVT_IDX_STATUS, 32'h00020003);
        wc(`CVT_IDX_VEC_ENABLE, 32'h0); wc(`CVT_IDX_VEC_ENABLE, 32'h1);
        rc(`CVT_IDX_VEC_PORT, vw(10'h0));
        wc(`CVT_IDX_VEC_ENABLE, 32'h0); wc(`CVT_IDX_VEC_ENABLE, 32'h1);
        for (i = 0; i < 673; i = i + 1) begin rv = rnd(); wexp[i] = rv[7:0]; end
        for (i = 0; i < 673; i = i + 1) wc(`CVT_IDX_VEC_PORT, {24'h0, wexp[i]});
        repeat (3) @(posedge clk);
        chk(n_wr, 673);
        halted <= 1'b0; // Access while running must raise the sticky flag
        rc(`CVT_IDX_VEC_PORT, vw(10'h0)); rc(`CVT_IDX_STATUS, 32'h00010006);
        wrap_up;
    end
endmodule // calibration_vector_and_trim_regs_tb

bind cvt_top cvt_props u_props (.clk_sys_i, .rst_n_i, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .cal_rd_o, .cal_wr_o, .cal_index_o);
